// ===== jle_cfg.svh
`ifndef JLE_CFG_SVH
`define JLE_CFG_SVH

// register offsets on the control port
`define JLE_ADDR_LVL_EN   8'h50
`define JLE_ADDR_LVL_THR  8'h51
`define JLE_ADDR_STATUS   8'hec
`define JLE_ADDR_FLAGS    8'hed
`define JLE_ADDR_MASK     8'hee

// field positions
`define JLE_BIT_JACK      7
`define JLE_BIT_LVL       0
`define JLE_EN_W          4
`define JLE_THR_W         7

// reset values
`define JLE_EN_RST        4'h0
`define JLE_THR_RST       7'h7f
`define JLE_MASK_RST      1'b0
`define JLE_FLAG_RST      1'b0
`define JLE_STS_RST       1'b0
`define JLE_DATA_RST      8'h00
`define JLE_IRQ_RST       1'b0

// level detect datapath: magnitude of a 24-bit sample, full scale 2^23
`define JLE_CHANNELS      4
`define JLE_MAG_W         23
`define JLE_THR_LSB_PAD   16'h0000
`define JLE_THR_STEP      8'h01

`endif

// ===== jle_event_irq.sv
// Operation
// [R01] status bit 7 reads 1 while a jack is inserted, 0 otherwise, and 0 after reset.
// [R02] a jack change latches event bit 7; writing 1 clears it and writing 0 keeps it.
// [R03] with mask bit 7 at 0 a latched jack flag drives the interrupt pin; at 1 it cannot.
// [R04] a level detect latches event bit 0, and mask bit 0 gates it onto the pin the same way.
// [R05] four enable bits select channel 1 left, 1 right, 2 left and 2 right for level detect.
// [R06] a 7-bit threshold x, reset to all ones, sets the level at (x+1)/128 of full scale.
// [R07] enabled channel over threshold sets level flag; pin low while any unmasked flag is set
`timescale 1ns/1ps
`include "jle_cfg.svh"

module jle_event_irq (
  input  wire logic                     clk_sys,
  input  wire logic                     srst,
  input  wire logic                     ce,
  input  wire jle_pkg::jle_reg_req_type req,
  output logic [7:0]                    rdata,
  input  wire logic                     jack_present,
  input  wire jle_pkg::jle_sample_type  samp,
  output logic                          irq_out_n_o,
  output logic                          irq_out_n_oe
);

  ////////////////////////////////////////////////////////////////////////////
  // jack pin synchroniser, three stages

  logic       js1_r, js2_r, js3_r, jack_lvl_r;
  logic       js1_nxt, js2_nxt, js3_nxt, jack_lvl_nxt;
  logic       jack_chg;

  // a level counts only when stages two and three agree
  always_comb
  begin
    js1_nxt      = jack_present;
    js2_nxt      = js1_r;
    js3_nxt      = js2_r;
    jack_chg     = (js2_r == js3_r) && (js3_r != jack_lvl_r);
    jack_lvl_nxt = jack_chg ? js3_r : jack_lvl_r; // R01
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      js1_r      <= `JLE_STS_RST;
      js2_r      <= `JLE_STS_RST;
      js3_r      <= `JLE_STS_RST;
      jack_lvl_r <= `JLE_STS_RST;
    end
    else if (ce)
    begin
      js1_r      <= js1_nxt;
      js2_r      <= js2_nxt;
      js3_r      <= js3_nxt;
      jack_lvl_r <= jack_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // level comparison per channel

  logic [`JLE_EN_W-1:0]  lvl_en_r, lvl_en_nxt;
  logic [`JLE_THR_W-1:0] thr_r, thr_nxt;
  logic [7:0]            thr_step;
  logic [`JLE_MAG_W:0]   thr_full;
  logic [`JLE_CHANNELS-1:0] hit;
  logic                  lvl_hit;

  // one extra bit so that x = 127 means exactly full scale
  assign thr_step = {1'b0, thr_r} + `JLE_THR_STEP; // R06
  assign thr_full = {thr_step, `JLE_THR_LSB_PAD};  // R06

  genvar g;
  generate
    for (g = 0; g < `JLE_CHANNELS; g = g + 1)
    begin : g_chan
      // disabled channels never hit, whatever their data
      assign hit[g] = lvl_en_r[g] && ({1'b0, samp.mag[g]} > thr_full); // R05
    end
  endgenerate

  assign lvl_hit = samp.valid && (|hit); // R07

  ////////////////////////////////////////////////////////////////////////////
  // registers, flags and interrupt

  logic wr_flags;
  logic flag_jack_r, flag_jack_nxt, flag_lvl_r, flag_lvl_nxt;
  logic msk_jack_r, msk_jack_nxt, msk_lvl_r, msk_lvl_nxt;
  logic irq_oe_r, irq_oe_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  assign wr_flags = req.wr && (req.addr == `JLE_ADDR_FLAGS);

  // set beats write-1-to-clear so an event in the clearing cycle is kept
  always_comb
  begin
    lvl_en_nxt    = lvl_en_r;
    thr_nxt       = thr_r;
    msk_jack_nxt  = msk_jack_r;
    msk_lvl_nxt   = msk_lvl_r;
    flag_jack_nxt = flag_jack_r;
    flag_lvl_nxt  = flag_lvl_r;
    if (req.wr && req.addr == `JLE_ADDR_LVL_EN)
      lvl_en_nxt = req.wdata[`JLE_EN_W-1:0]; // R05
    if (req.wr && req.addr == `JLE_ADDR_LVL_THR)
      thr_nxt = req.wdata[`JLE_THR_W-1:0]; // R06
    if (req.wr && req.addr == `JLE_ADDR_MASK)
    begin
      msk_jack_nxt = req.wdata[`JLE_BIT_JACK];
      msk_lvl_nxt  = req.wdata[`JLE_BIT_LVL];
    end
    if (wr_flags && req.wdata[`JLE_BIT_JACK])
      flag_jack_nxt = 1'b0; // R02
    if (wr_flags && req.wdata[`JLE_BIT_LVL])
      flag_lvl_nxt = 1'b0;
    if (jack_chg)
      flag_jack_nxt = 1'b1; // R02
    if (lvl_hit)
      flag_lvl_nxt = 1'b1; // R04
    // pin follows the latched flags one cycle later
    irq_oe_nxt = (flag_jack_r && !msk_jack_r) || (flag_lvl_r && !msk_lvl_r); // R03 R04 R07
    case (req.addr)
      `JLE_ADDR_LVL_EN:  rdata_nxt = {4'h0, lvl_en_r};
      `JLE_ADDR_LVL_THR: rdata_nxt = {1'b0, thr_r};
      `JLE_ADDR_STATUS:  rdata_nxt = {jack_lvl_r, 7'h00}; // R01
      `JLE_ADDR_FLAGS:   rdata_nxt = {flag_jack_r, 6'h00, flag_lvl_r};
      `JLE_ADDR_MASK:    rdata_nxt = {msk_jack_r, 6'h00, msk_lvl_r};
      default:           rdata_nxt = `JLE_DATA_RST;
    endcase
    if (!req.rd)
      rdata_nxt = rdata_r;
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      lvl_en_r    <= `JLE_EN_RST;
      thr_r       <= `JLE_THR_RST; // R06
      msk_jack_r  <= `JLE_MASK_RST; // R03
      msk_lvl_r   <= `JLE_MASK_RST;
      flag_jack_r <= `JLE_FLAG_RST;
      flag_lvl_r  <= `JLE_FLAG_RST;
      irq_oe_r    <= `JLE_IRQ_RST;
      rdata_r     <= `JLE_DATA_RST;
    end
    else if (ce)
    begin
      lvl_en_r    <= lvl_en_nxt;
      thr_r       <= thr_nxt;
      msk_jack_r  <= msk_jack_nxt;
      msk_lvl_r   <= msk_lvl_nxt;
      flag_jack_r <= flag_jack_nxt;
      flag_lvl_r  <= flag_lvl_nxt;
      irq_oe_r    <= irq_oe_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // open-drain style: only ever pulls low
  assign irq_out_n_o  = 1'b0;
  assign irq_out_n_oe = irq_oe_r;
  assign rdata        = rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  a_jack_status_follow: assert property (@(posedge clk_sys) disable iff (srst) // R01
    ce && js2_r == js3_r |=> jack_lvl_r == $past(js3_r))
    else $error("jack status did not follow settled pin");

  a_status_read_back: assert property (@(posedge clk_sys) disable iff (srst) // R01
    ce && req.rd && req.addr == `JLE_ADDR_STATUS
      |=> rdata == {$past(jack_lvl_r), 7'h00})
    else $error("status read does not show jack level");

  a_jack_flag_set: assert property (@(posedge clk_sys) disable iff (srst) // R02
    ce && jack_chg |=> flag_jack_r)
    else $error("jack change not latched");

  a_jack_flag_clear: assert property (@(posedge clk_sys) disable iff (srst) // R02
    ce && !jack_chg && wr_flags && req.wdata[`JLE_BIT_JACK] |=> !flag_jack_r)
    else $error("write one did not clear jack flag");

  a_jack_flag_hold: assert property (@(posedge clk_sys) disable iff (srst) // R02
    ce && flag_jack_r && !(wr_flags && req.wdata[`JLE_BIT_JACK]) |=> flag_jack_r)
    else $error("jack flag lost without a clearing write");

  a_irq_jack_unmask: assert property (@(posedge clk_sys) disable iff (srst) // R03
    ce && flag_jack_r && !msk_jack_r |=> irq_out_n_oe)
    else $error("unmasked jack flag not on pin");

  a_lvl_flag_set: assert property (@(posedge clk_sys) disable iff (srst) // R04
    ce && lvl_hit |=> flag_lvl_r ##1 (irq_out_n_oe || $past(msk_lvl_r) || !$past(ce)))
    else $error("level hit not latched or not signalled");

  a_lvl_en_gate: assert property (@(posedge clk_sys) disable iff (srst) // R05
    ce && lvl_en_r == 4'h0 && !flag_lvl_r |=> !flag_lvl_r)
    else $error("level flag set with all channels disabled");

  a_thr_write: assert property (@(posedge clk_sys) disable iff (srst) // R06
    ce && req.wr && req.addr == `JLE_ADDR_LVL_THR
      |=> thr_r == $past(req.wdata[`JLE_THR_W-1:0]))
    else $error("threshold write not taken");

  a_irq_release: assert property (@(posedge clk_sys) disable iff (srst) // R07
    ce && !(flag_jack_r && !msk_jack_r) && !(flag_lvl_r && !msk_lvl_r) |=> !irq_out_n_oe)
    else $error("pin held low with no unmasked flag");

  // level flag clears like the jack flag unless a hit lands in the same cycle
  a_lvl_flag_clear: assert property (@(posedge clk_sys) disable iff (srst) // R04
    ce && !lvl_hit && wr_flags && req.wdata[`JLE_BIT_LVL] |=> !flag_lvl_r)
    else $error("write one did not clear level flag");

  a_irq_lvl_unmask: assert property (@(posedge clk_sys) disable iff (srst) // R04
    ce && flag_lvl_r && !msk_lvl_r |=> irq_out_n_oe)
    else $error("unmasked level flag not on pin");

  a_mask_write: assert property (@(posedge clk_sys) disable iff (srst) // R03
    ce && req.wr && req.addr == `JLE_ADDR_MASK
      |=> msk_jack_r == $past(req.wdata[`JLE_BIT_JACK])
        && msk_lvl_r == $past(req.wdata[`JLE_BIT_LVL]))
    else $error("mask write not taken");

  a_en_write: assert property (@(posedge clk_sys) disable iff (srst) // R05
    ce && req.wr && req.addr == `JLE_ADDR_LVL_EN
      |=> lvl_en_r == $past(req.wdata[`JLE_EN_W-1:0]))
    else $error("channel enable write not taken");

endmodule

// ===== jle_host_model.sv
`timescale 1ns/1ps
// host end of the open-drain interrupt line
module jle_host_model (
  input  wire logic irq_out_n_o,
  input  wire logic irq_out_n_oe,
  output logic      irq_n
);
  // pull-up: a released line reads high, never a stale level
  assign irq_n = irq_out_n_oe ? irq_out_n_o : 1'b1;
endmodule

// ===== jle_pkg.sv
package jle_pkg;

  // one register access from the control interface
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } jle_reg_req_type;

  // one set of record-path magnitudes, all four channels together
  typedef struct packed {
    logic             valid;
    logic [3:0][22:0] mag;
  } jle_sample_type;

endpackage

// ===== tb.sv
`timescale 1ns/1ps
module tb;
  logic                     clk_sys = 1'b0;
  logic                     srst = 1'b1;
  logic                     ce = 1'b1;
  logic                     jack_present = 1'b0;
  jle_pkg::jle_reg_req_type req = '0;
  jle_pkg::jle_sample_type  samp = '0;
  logic [7:0]               rdata;
  logic                     irq_out_n_o;
  logic                     irq_out_n_oe;
  logic                     irq_n;
  logic                     pend = 1'b0;
  logic [7:0]               expq[$];
  logic [3:0][22:0]         m;
  logic [6:0]               x;
  logic [7:0]               ra[6] = '{8'h50, 8'h51, 8'hec, 8'hed, 8'hee, 8'h10};
  logic [7:0]               rv[6] = '{8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]               wv[6] = '{8'h0f, 8'h7f, 8'h00, 8'h00, 8'h81, 8'h00};
  int                       n_mismatch = 0;
  int                       cmp_count = 0;
  int                       seed = 53908;

  // 200 MHz system clock
  always #2.5 clk_sys = ~clk_sys;

  jle_event_irq i_dut (.clk_sys(clk_sys), .srst(srst), .ce(ce), .req(req), .rdata(rdata),
    .jack_present(jack_present), .samp(samp), .irq_out_n_o(irq_out_n_o),
    .irq_out_n_oe(irq_out_n_oe));
  jle_host_model i_host (.irq_out_n_o(irq_out_n_o), .irq_out_n_oe(irq_out_n_oe),
    .irq_n(irq_n));

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // one access, then a quiet edge so the strobe is never reassigned in one step
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] e);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    if (!w)
      expq.push_back(e);
    @(posedge clk_sys);
    req <= '0;
    @(posedge clk_sys);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  task automatic smp(input logic [3:0][22:0] v);
    samp <= '{valid: 1'b1, mag: v};
    @(posedge clk_sys);
    samp <= '0;
    @(posedge clk_sys);
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // read data settles one edge after the taken read
  always @(posedge clk_sys)
  begin
    if (pend && expq.size() > 0)
      chk(rdata, expq.pop_front());
    pend <= req.rd;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    finish_test();
  end

  // main sequence
  initial
  begin
    idle(3);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (ra[i]) acc(1'b0, ra[i], 8'h00, rv[i]);
    chk({7'h00, irq_n}, 8'h01);
    foreach (ra[i]) acc(1'b1, ra[i], 8'hff, 8'h00);
    foreach (ra[i]) acc(1'b0, ra[i], 8'h00, wv[i]);
    acc(1'b1, 8'hee, 8'h00, 8'h00);
    $display("register test done");
    jack_present <= 1'b1;
    idle(6);
    acc(1'b0, 8'hec, 8'h00, 8'h80);
    acc(1'b1, 8'hed, 8'h00, 8'h00);
    acc(1'b0, 8'hed, 8'h00, 8'h80);
    chk({7'h00, irq_n}, 8'h00);
    acc(1'b1, 8'hee, 8'h80, 8'h00);
    idle(2);
    chk({7'h00, irq_n}, 8'h01);
    acc(1'b1, 8'hee, 8'h00, 8'h00);
    idle(2);
    chk({7'h00, irq_n}, 8'h00);
    acc(1'b1, 8'hed, 8'h80, 8'h00);
    jack_present <= 1'b0;
    idle(6);
    acc(1'b0, 8'hec, 8'h00, 8'h00);
    acc(1'b0, 8'hed, 8'h00, 8'h80);
    acc(1'b1, 8'hed, 8'h80, 8'h00);
    idle(2);
    chk({7'h00, irq_n}, 8'h01);
    $display("jack test done");
    // one channel enabled at a time, the disabled ones sit at full scale
    for (int c = 0; c < 4; c++)
    begin
      x = 7'({$random(seed)} % 127);
      m = {4{23'h7fffff}};
      m[c] = {x + 7'h01, 16'h0000};
      acc(1'b1, 8'h50, 8'(1 << c), 8'h00);
      acc(1'b1, 8'h51, {1'b0, x}, 8'h00);
      acc(1'b1, 8'hee, {7'h00, c[0]}, 8'h00);
      smp(m);
      acc(1'b0, 8'hed, 8'h00, 8'h00);
      m[c] = m[c] + 23'h1;
      smp(m);
      acc(1'b0, 8'hed, 8'h00, 8'h01);
      chk({7'h00, irq_n}, {7'h00, c[0]});
      acc(1'b1, 8'hed, 8'h01, 8'h00);
      acc(1'b1, 8'hee, 8'h00, 8'h00);
      $display("level test channel %0d done", c);
    end
    // a frozen block must ignore both a register write and a sample hit
    ce <= 1'b0;
    acc(1'b1, 8'hee, 8'hff, 8'h00);
    smp({4{23'h7fffff}});
    ce <= 1'b1;
    acc(1'b0, 8'hee, 8'h00, 8'h00);
    acc(1'b0, 8'hed, 8'h00, 8'h00);
    $display("clock enable test done");
    // mid-run reset with a latched, masked level flag and a changed threshold
    acc(1'b1, 8'h51, 8'h05, 8'h00);
    acc(1'b1, 8'hee, 8'h81, 8'h00);
    smp({4{23'h7fffff}});
    acc(1'b0, 8'hed, 8'h00, 8'h01);
    chk({7'h00, irq_n}, 8'h01);
    srst <= 1'b1;
    idle(2);
    srst <= 1'b0;
    @(posedge clk_sys);
    foreach (ra[i]) acc(1'b0, ra[i], 8'h00, rv[i]);
    chk({7'h00, irq_n}, 8'h01);
    $display("reset test done");
    finish_test();
  end
endmodule
